// >>> hw/vsrp_packer.sv
// sliced result packer: line modes, config ram port, result fifo, packets
`include "vsrp_map.svh"
// ============================================================
module vsrp_packer #(
   parameter int LB_DEPTH   = 64,                // line buffer bytes, at most 240
   parameter int FIFO_DEPTH = `VSRP_FIFO_DEPTH,  // result fifo bytes
   parameter int CRAM_DEPTH = 256                // config ram entries
) (
   input  wire logic       mclk,
   input  wire logic       arst_n,
   input  wire logic       ce,         // freezes all state when low
   input  wire logic [7:0] reg_addr,   // host subaddress
   input  wire logic       reg_wr,     // host write strobe
   input  wire logic       reg_rd,     // host read strobe
   input  wire logic [7:0] reg_wdata,  // host write byte
   output logic      [7:0] reg_rdata,  // host read byte, one cycle after strobe
   input  wire logic       slc_valid,  // sliced byte of current line
   input  wire logic [7:0] slc_data,   // sliced byte value
   input  wire logic       slc_last,   // line finished, metadata valid
   input  wire logic [9:0] slc_line,   // line number of finished line
   input  wire logic       slc_field,  // 0 first field, 1 second
   input  wire logic       slc_err,    // error seen by the error checker
   input  wire logic       slc_match1, // match 1 flag
   input  wire logic       slc_match2, // match 2 flag
   input  wire logic       hblank,     // horizontal blanking window
   output logic            anc_valid,  // packet byte toward receiver
   output logic      [7:0] anc_data,   // packet byte value
   input  wire logic       anc_ready   // receiver takes byte
);
   localparam int LBW = $clog2(LB_DEPTH);
   localparam int FW  = $clog2(FIFO_DEPTH);
   localparam int CW  = $clog2(CRAM_DEPTH);

   // ============================================================
   // storage
   logic [7:0]        lmode_reg [`VSRP_LMODE_CNT];  // per-line service select
   logic [7:0]        bank_reg  [`VSRP_BANK_SIZE];  // dedicated result bytes
   logic [7:0]        fifo_mem  [FIFO_DEPTH];       // result fifo
   logic [7:0]        cram_mem  [CRAM_DEPTH];       // slicer config ram
   logic [7:0]        lbuf_mem  [LB_DEPTH];         // bytes of last line
   logic [7:0]        ctrl_reg;                     // anc, routing, full field
   logic [7:0]        reg_rdata_reg;                // registered read data
   logic [FW-1:0]     fwp_reg;                      // fifo write pointer
   logic [FW-1:0]     frp_reg;                      // fifo read pointer
   logic [FW:0]       fcnt_reg;                     // fifo fill level
   logic              ovf_reg;                      // sticky fifo overflow
   logic [CW-1:0]     cram_ptr_reg;                 // auto-increment location
   logic [LBW:0]      lwp_reg;                      // line buffer fill
   logic [LBW-1:0]    lrp_reg;                      // line buffer read index
   // latched line metadata
   logic              pend_reg;
   logic [3:0]        code_reg;
   logic [2:0]        did_reg;
   logic [9:0]        line_reg;
   logic [2:0]        flg_reg;
   logic [LBW:0]      dlen_reg;
   // packet former
   vsrp_pkg::vsrp_state_t state_reg;
   logic [7:0]        idx_reg;                      // byte number in packet
   logic [7:0]        cs_reg;                       // running checksum
   logic              anc_on_reg;                   // insertion latched per packet
   // combinational
   logic              lm_hit;
   logic [5:0]        lm_idx;
   logic [7:0]        lm_val;
   logic [LBW+1:0]    nn_sum;
   logic [7:0]        pkt_byte;
   logic              tt, to_fifo, to_bank, busy, step, start;
   logic              fwr, frd, acc_cram, ovf_clr;

   vsrp_buf_if #(.W(8)) bu ();
   vsrp_buf_if #(.W(8)) bd ();

   // header byte with parity pair on top
   function automatic logic [7:0] hdr_byte(input logic [5:0] v);
      logic p;
      p = ^v;
      return {~p, p, v};
   endfunction : hdr_byte

   // subaddress window test, used by write and read decode
   function automatic logic in_win(input logic [7:0] a, input logic [7:0] lo,
                                   input logic [7:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction : in_win

   // ============================================================
   // service lookup for the finished line
   always_comb begin
      lm_hit = (slc_line >= `VSRP_LINE_FIRST) && (slc_line <= `VSRP_LINE_LAST);
      lm_idx = 6'(slc_line - `VSRP_LINE_FIRST) + (slc_field ? `VSRP_LINES_FLD : 6'h00);
      lm_val = lm_hit ? lmode_reg[lm_idx] : `VSRP_LMODE_OFF;
   end

   // ============================================================
   // packet byte selection
   always_comb begin
      nn_sum   = (LBW+2)'(dlen_reg) + (LBW+2)'(3'h4);
      tt       = code_reg <= `VSRP_TT_LAST;
      // teletext forced to fifo, others routed by control
      to_fifo  = tt | ctrl_reg[`VSRP_C_NTT_FIFO];
      to_bank  = ~tt & ctrl_reg[`VSRP_C_NTT_BANK];
      busy     = state_reg != vsrp_pkg::ST_IDLE;
      step     = ce & busy & (~anc_on_reg | bu.ready);
      start    = ce & ~busy & pend_reg & hblank;
      pkt_byte = `VSRP_FILL;
      case (state_reg)
         vsrp_pkg::ST_HDR: begin
            case (idx_reg[2:0])
               3'h0: pkt_byte = `VSRP_PRE_ZERO;
               3'h1: pkt_byte = `VSRP_PRE_ONE;
               3'h2: pkt_byte = `VSRP_PRE_ONE;
               3'h3: pkt_byte = hdr_byte({`VSRP_DID_FIX, did_reg});
               3'h4: pkt_byte = hdr_byte({2'b00, code_reg});
               3'h5: pkt_byte = hdr_byte(6'(nn_sum >> 2));
               3'h6: pkt_byte = line_reg[7:0];
               default: pkt_byte = {3'b000, flg_reg, line_reg[9:8]};
            endcase
         end
         vsrp_pkg::ST_DATA: pkt_byte = lbuf_mem[lrp_reg];
         // checksum byte carries parity pair too
         vsrp_pkg::ST_CSUM: pkt_byte = hdr_byte(cs_reg[5:0]);
         default: pkt_byte = `VSRP_FILL;
      endcase
   end

   // bytes offered only when insertion enabled
   assign bu.valid = busy & anc_on_reg;
   assign bu.data  = pkt_byte;
   assign bd.ready = anc_ready;
   assign anc_valid = bd.valid;
   assign anc_data  = bd.data;

   vsrp_skid_buf u_buf (
      .mclk   (mclk),
      .arst_n (arst_n),
      .ce     (ce),
      .up     (bu),
      .dn     (bd)
   );

   // ============================================================
   // line intake: bytes land in the line buffer, metadata at line end
   // limitation: the slicer must not deliver the next line before the packet ends
   always_ff @(posedge mclk) begin
      if (ce && slc_valid && lwp_reg < LB_DEPTH) begin
         lbuf_mem[LBW'(lwp_reg)] <= slc_data;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         lwp_reg  <= '0;
         pend_reg <= 1'b0;
         code_reg <= 4'h0;
         did_reg  <= 3'h0;
         line_reg <= 10'h000;
         flg_reg  <= 3'h0;
         dlen_reg <= '0;
      end else if (ce) begin
         if (slc_last) begin
            // service code from the per-line register, FFh means off
            pend_reg <= (lm_val != `VSRP_LMODE_OFF) | ctrl_reg[`VSRP_C_FULL];
            code_reg <= (lm_val != `VSRP_LMODE_OFF) ? lm_val[3:0] : `VSRP_FULL_CODE;
            // identifier by field and line 24 split
            did_reg  <= slc_field ?
                        ((slc_line >= `VSRP_LINE_HI) ? `VSRP_ID_F2_HI : `VSRP_ID_F2_VBI) :
                        ((slc_line >= `VSRP_LINE_HI) ? `VSRP_ID_F1_HI : `VSRP_ID_F1_VBI);
            line_reg <= slc_line;
            flg_reg  <= {slc_err, slc_match1, slc_match2};
            dlen_reg <= lwp_reg;
            lwp_reg  <= '0;
         end else begin
            if (slc_valid && lwp_reg < LB_DEPTH) begin
               lwp_reg <= lwp_reg + 1'b1;
            end
            if (start) begin
               pend_reg <= 1'b0;
            end
         end
      end
   end

   // ============================================================
   // packet former
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg  <= vsrp_pkg::ST_IDLE;
         idx_reg    <= 8'h00;
         cs_reg     <= 8'h00;
         lrp_reg    <= '0;
         anc_on_reg <= 1'b0;
      end else if (start) begin
         // packet begins in the blanking after its line
         state_reg  <= vsrp_pkg::ST_HDR;
         idx_reg    <= 8'h00;
         cs_reg     <= 8'h00;
         lrp_reg    <= '0;
         anc_on_reg <= ctrl_reg[`VSRP_C_ANC];
      end else if (step) begin
         idx_reg <= idx_reg + 8'h01;
         // sum from identifier byte through last data byte
         if ((state_reg == vsrp_pkg::ST_HDR && idx_reg >= 8'h03) ||
             state_reg == vsrp_pkg::ST_DATA) begin
            cs_reg <= cs_reg + pkt_byte;
         end
         case (state_reg)
            vsrp_pkg::ST_HDR: begin
               if (idx_reg[2:0] == 3'h7) begin
                  state_reg <= (dlen_reg == '0) ? vsrp_pkg::ST_CSUM : vsrp_pkg::ST_DATA;
               end
            end
            vsrp_pkg::ST_DATA: begin
               lrp_reg <= lrp_reg + 1'b1;
               if ((LBW+1)'(lrp_reg) == dlen_reg - 1'b1) begin
                  state_reg <= vsrp_pkg::ST_CSUM;
               end
            end
            // zero fill until length is a four-byte multiple
            vsrp_pkg::ST_CSUM,
            vsrp_pkg::ST_FILL: begin
               state_reg <= (idx_reg[1:0] == 2'b11) ? vsrp_pkg::ST_IDLE :
                                                      vsrp_pkg::ST_FILL;
            end
            default: state_reg <= vsrp_pkg::ST_IDLE;
         endcase
      end
   end

   // ============================================================
   // result fifo; full drops the byte and flags overflow rather than stall
   assign fwr     = step & to_fifo & (fcnt_reg < FIFO_DEPTH);
   assign frd     = ce & reg_rd & (reg_addr == `VSRP_FIFO_PORT) & (fcnt_reg != '0);
   assign ovf_clr = ce & reg_rd & (reg_addr == `VSRP_FSTAT);

   // same byte stream feeds fifo and stream
   always_ff @(posedge mclk) begin
      if (fwr) begin
         fifo_mem[fwp_reg] <= pkt_byte;
      end
      // non-teletext bytes into the dedicated bank
      if (step && to_bank && state_reg == vsrp_pkg::ST_DATA &&
          lrp_reg < `VSRP_BANK_SIZE) begin
         bank_reg[5'(lrp_reg)] <= pkt_byte;
      end
      if (ce && reg_wr && reg_addr == `VSRP_CRAM_PORT) begin
         cram_mem[cram_ptr_reg] <= reg_wdata;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         fwp_reg  <= '0;
         frp_reg  <= '0;
         fcnt_reg <= '0;
         ovf_reg  <= 1'b0;
      end else if (ce) begin
         fwp_reg  <= fwp_reg + FW'(fwr);
         frp_reg  <= frp_reg + FW'(frd);
         fcnt_reg <= fcnt_reg + (FW+1)'(fwr) - (FW+1)'(frd);
         // overflow set wins over the read clear
         if (step && to_fifo && !fwr) begin
            ovf_reg <= 1'b1;
         end else if (ovf_clr) begin
            ovf_reg <= 1'b0;
         end
      end
   end

   // ============================================================
   // host registers
   assign acc_cram = ce & (reg_wr | reg_rd) & (reg_addr == `VSRP_CRAM_PORT);

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_reg     <= `VSRP_CTRL_RST;
         cram_ptr_reg <= '0;
         for (int i = 0; i < `VSRP_LMODE_CNT; i++) begin
            lmode_reg[i] <= `VSRP_LMODE_OFF;
         end
      end else if (ce) begin
         // every port access moves to the next entry
         if (acc_cram) begin
            cram_ptr_reg <= cram_ptr_reg + 1'b1;
         end else if (reg_wr && reg_addr == `VSRP_CRAM_ADDR) begin
            cram_ptr_reg <= CW'(reg_wdata);
         end
         if (reg_wr && reg_addr == `VSRP_CTRL) begin
            ctrl_reg <= reg_wdata;
         end
         if (reg_wr && in_win(reg_addr, `VSRP_LMODE_BASE, `VSRP_LMODE_LAST)) begin
            lmode_reg[6'(reg_addr - `VSRP_LMODE_BASE)] <= reg_wdata;
         end
      end
   end

   // read mux, registered so the host port sees a flop
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata_reg <= 8'h00;
      end else if (ce && reg_rd) begin
         if (in_win(reg_addr, `VSRP_BANK_BASE, `VSRP_BANK_LAST)) begin
            reg_rdata_reg <= bank_reg[5'(reg_addr - `VSRP_BANK_BASE)];
         end else if (in_win(reg_addr, `VSRP_LMODE_BASE, `VSRP_LMODE_LAST)) begin
            reg_rdata_reg <= lmode_reg[6'(reg_addr - `VSRP_LMODE_BASE)];
         end else begin
            case (reg_addr)
               `VSRP_FIFO_PORT: reg_rdata_reg <= frd ? fifo_mem[frp_reg] : 8'h00;
               `VSRP_CTRL:      reg_rdata_reg <= ctrl_reg;
               `VSRP_FCNT_LO:   reg_rdata_reg <= 8'(fcnt_reg);
               `VSRP_FSTAT:     reg_rdata_reg <= {ovf_reg, 7'(fcnt_reg >> 8)};
               `VSRP_CRAM_PORT: reg_rdata_reg <= cram_mem[cram_ptr_reg];
               `VSRP_CRAM_ADDR: reg_rdata_reg <= 8'(cram_ptr_reg);
               default:         reg_rdata_reg <= 8'h00;
            endcase
         end
      end
   end
   assign reg_rdata = reg_rdata_reg;

   // ============================================================
   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   chk_pre_zero: assert property (step && state_reg == vsrp_pkg::ST_HDR && idx_reg == 8'h00 |-> pkt_byte == 8'h00 ##1 pkt_byte == 8'hFF) else $error("bad preamble");
   chk_did_fixed: assert property (busy && state_reg == vsrp_pkg::ST_HDR && idx_reg == 8'h03 |-> pkt_byte[5:3] == 3'b010) else $error("bad id bits");
   chk_hdr_parity: assert property (busy && state_reg == vsrp_pkg::ST_HDR && idx_reg inside {8'h03, 8'h04, 8'h05} |-> pkt_byte[6] == ^pkt_byte[5:0] && pkt_byte[7] != pkt_byte[6]) else $error("bad parity");
   chk_tt_fifo: assert property (busy && tt |-> to_fifo && !to_bank) else $error("teletext misrouted");
   chk_cram_step: assert property (acc_cram |=> cram_ptr_reg == CW'($past(cram_ptr_reg) + 1'b1)) else $error("ram pointer stuck");
   chk_fill_align: assert property (step && state_reg == vsrp_pkg::ST_FILL && idx_reg[1:0] == 2'b11 |=> state_reg == vsrp_pkg::ST_IDLE && idx_reg[1:0] == 2'b00) else $error("fill misaligned");
   chk_fifo_bound: assert property (fcnt_reg <= FIFO_DEPTH) else $error("fifo level over size");
   chk_start_blank: assert property (state_reg == vsrp_pkg::ST_IDLE ##1 state_reg == vsrp_pkg::ST_HDR |-> $past(hblank) && $past(pend_reg)) else $error("packet outside blanking");
   chk_csum_byte: assert property (busy && state_reg == vsrp_pkg::ST_CSUM |-> pkt_byte[5:0] == cs_reg[5:0]) else $error("bad checksum");
   chk_anc_gate: assert property (bu.valid |-> anc_on_reg) else $error("insertion while off");

   cov_packet: cover property (step && state_reg == vsrp_pkg::ST_CSUM);
   cov_stall: cover property (busy && anc_on_reg && !bu.ready);
   cov_ovf: cover property (ovf_reg);
   cov_bank: cover property (step && to_bank);
endmodule : vsrp_packer

// >>> common/vsrp_map.svh
// offsets, field positions, reset values and fixed codes of the result packer
`ifndef VSRP_MAP_SVH
`define VSRP_MAP_SVH
// ============================================================
// register subaddresses
`define VSRP_BANK_BASE   8'h90
`define VSRP_BANK_LAST   8'hAF
`define VSRP_FIFO_PORT   8'hB0
`define VSRP_CTRL        8'hC0
`define VSRP_FCNT_LO     8'hC1
`define VSRP_FSTAT       8'hC2
`define VSRP_CRAM_PORT   8'hC3
`define VSRP_CRAM_ADDR   8'hC4
`define VSRP_LMODE_BASE  8'hD0
`define VSRP_LMODE_LAST  8'hFC
`define VSRP_LMODE_CNT   45
`define VSRP_LMODE_OFF   8'hFF
`define VSRP_BANK_SIZE   32
`define VSRP_FIFO_DEPTH  512
// ============================================================
// control register bits
`define VSRP_C_ANC       0
`define VSRP_C_NTT_FIFO  1
`define VSRP_C_NTT_BANK  2
`define VSRP_C_FULL      3
`define VSRP_CTRL_RST    8'h02
// ============================================================
// line window and packet codes
`define VSRP_LINE_FIRST  10'h006
`define VSRP_LINE_LAST   10'h01B
`define VSRP_LINE_HI     10'h018
`define VSRP_LINES_FLD   6'h16
`define VSRP_TT_LAST     4'h5
`define VSRP_FULL_CODE   4'hF
`define VSRP_PRE_ZERO    8'h00
`define VSRP_PRE_ONE     8'hFF
`define VSRP_DID_FIX     3'h2
`define VSRP_ID_F1_VBI   3'h1
`define VSRP_ID_F1_HI    3'h3
`define VSRP_ID_F2_VBI   3'h5
`define VSRP_ID_F2_HI    3'h7
`define VSRP_FILL        8'h00
`endif

// >>> common/vsrp_pkg.sv
// types shared by the result packer files
package vsrp_pkg;
   // packet former states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_HDR  = 3'b001,
      ST_DATA = 3'b010,
      ST_CSUM = 3'b011,
      ST_FILL = 3'b100
   } vsrp_state_t;
endpackage : vsrp_pkg

// >>> common/vsrp_buf_if.sv
// valid/ready byte carrier between packer and its output buffer
interface vsrp_buf_if #(parameter int W = 8);
   logic         valid;  // byte offered
   logic         ready;  // byte can be taken
   logic [W-1:0] data;   // byte value
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : vsrp_buf_if

// >>> hw/vsrp_skid_buf.sv
// two-entry buffer so that a receiver stall loses no packet byte
module vsrp_skid_buf (
   input  wire logic  mclk,
   input  wire logic  arst_n,
   input  wire logic  ce,
   vsrp_buf_if.snk    up,
   vsrp_buf_if.src    dn
);
   // ============================================================
   // storage: slot0 faces the receiver, slot1 catches a stall
   logic [7:0] d0_reg;  // head byte
   logic [7:0] d1_reg;  // spare byte
   logic       v0_reg;  // head valid
   logic       v1_reg;  // spare valid
   logic       push;
   logic       pop;

   // ready straight from the spare flag, so no path through the receiver
   assign up.ready = ~v1_reg;
   assign dn.valid = v0_reg;
   assign dn.data  = d0_reg;
   assign push     = up.valid & ~v1_reg;
   assign pop      = v0_reg & dn.ready;

   // slot update
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         v0_reg <= 1'b0;
         v1_reg <= 1'b0;
         d0_reg <= 8'h00;
         d1_reg <= 8'h00;
      end else if (ce) begin
         if (v1_reg) begin
            // full: only drain, spare moves to head
            if (pop) begin
               d0_reg <= d1_reg;
               v1_reg <= 1'b0;
            end
         end else if (v0_reg) begin
            if (push && pop) begin
               d0_reg <= up.data;
            end else if (push) begin
               d1_reg <= up.data;
               v1_reg <= 1'b1;
            end else if (pop) begin
               v0_reg <= 1'b0;
            end
         end else if (push) begin
            d0_reg <= up.data;
            v0_reg <= 1'b1;
         end
      end
   end
endmodule : vsrp_skid_buf

// >>> tb/vsrp_rx_model.sv
// downstream receiver model that stalls at random
module vsrp_rx_model (
   input  wire logic       mclk,
   input  wire logic       anc_valid,
   input  wire logic [7:0] anc_data,
   output logic            anc_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got_q[$];  // bytes taken, oldest first
   // ============================================================
   // take on valid and ready, then redraw ready so the buffer fills
   initial anc_ready = 1'h0;
   always @(posedge mclk) begin
      if (anc_valid === 1'h1 && anc_ready === 1'h1) got_q.push_back(anc_data);
      #1 anc_ready = 1'($urandom_range(1, 0));
   end
endmodule : vsrp_rx_model

// >>> tb/tb_top.sv
// self-checking bench for the sliced result packer
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic       mclk, arst_n, reg_wr, reg_rd, slc_valid, slc_last, slc_field;
   logic       slc_err, slc_m1, slc_m2, hblank, anc_valid, anc_ready;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, slc_data, anc_data, d, bank;
   logic [9:0] slc_line;
   logic [7:0] exp_q[$], dat_q[$];  // expected packet, line payload
   int         error_cnt, checked;
   vsrp_packer uut (.mclk(mclk), .arst_n(arst_n), .ce(1'h1), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .slc_valid(slc_valid), .slc_data(slc_data), .slc_last(slc_last),
      .slc_line(slc_line), .slc_field(slc_field), .slc_err(slc_err),
      .slc_match1(slc_m1), .slc_match2(slc_m2), .hblank(hblank), .anc_valid(anc_valid),
      .anc_data(anc_data), .anc_ready(anc_ready));
   vsrp_rx_model rx (.mclk(mclk), .anc_valid(anc_valid), .anc_data(anc_data),
      .anc_ready(anc_ready));
   always #5 mclk = ~mclk;
   // ============================================================
   // tasks: strobes stay up between calls, idle drops them
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      reg_addr = a;
      reg_wdata = v;
      reg_rd = 1'h0;
      reg_wr = 1'h1;
      @(posedge mclk);
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      reg_addr = a;
      reg_wr = 1'h0;
      reg_rd = 1'h1;
      @(posedge mclk);
      #1 d = reg_rdata;
   endtask : rd
   task automatic idle;
      reg_wr = 1'h0;
      reg_rd = 1'h0;
      @(posedge mclk);
      #1;
   endtask : idle
   task automatic chk(input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : chk
   task automatic final_report;
      $display("checked=%0d error_cnt=%0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : final_report
   // header byte: parity pair over the low six bits
   function automatic logic [7:0] hdr(input logic [5:0] v);
      return {~^v, ^v, v};
   endfunction : hdr
   function automatic void mk_pkt(input logic [3:0] c, input logic [9:0] ln,
                                  input logic f, input logic [2:0] flg);
      logic [7:0] s;
      int         nn;
      nn = (dat_q.size() + 4) >> 2;
      exp_q = {8'h00, 8'hFF, 8'hFF};
      exp_q.push_back(f ? (ln >= 24 ? 8'h97 : 8'h55) : (ln >= 24 ? 8'h53 : 8'h91));
      exp_q.push_back(hdr({2'h0, c}));
      exp_q.push_back(hdr(6'(nn)));
      exp_q.push_back(ln[7:0]);
      exp_q.push_back({3'h0, flg, ln[9:8]});
      foreach (dat_q[i]) exp_q.push_back(dat_q[i]);
      s = 8'h00;
      for (int i = 3; i < exp_q.size(); i++) s += exp_q[i];
      exp_q.push_back(hdr(s[5:0]));
      while (exp_q.size() < 8 + 4 * nn) exp_q.push_back(8'h00);
   endfunction : mk_pkt
   // ============================================================
   // one line through intake, stream and fifo
   task automatic pkt(input logic [3:0] c);
      logic [9:0] ln;
      logic       f;
      logic [2:0] flg;
      int         n;
      ln = 10'($urandom_range(27, 6));
      f = 1'($urandom);
      flg = 3'($urandom);
      dat_q = {};
      repeat ($urandom_range(40, 1)) dat_q.push_back(8'($urandom));
      mk_pkt(c, ln, f, flg);
      wr(8'hD0 + 8'(f * 22 + ln - 6), {4'h0, c});
      idle();
      foreach (dat_q[i]) begin
         slc_valid = 1'h1;
         slc_data = dat_q[i];
         @(posedge mclk);
         #1;
      end
      slc_valid = 1'h0;
      slc_last = 1'h1;
      slc_line = ln;
      slc_field = f;
      {slc_err, slc_m1, slc_m2} = flg;
      @(posedge mclk);
      #1 slc_last = 1'h0;
      repeat (6) @(posedge mclk);
      chk(8'h00, 8'(rx.got_q.size()));
      #1 hblank = 1'h1;
      n = 0;
      while (rx.got_q.size() < exp_q.size() && n < 2000) begin
         @(posedge mclk);
         n++;
      end
      repeat (4) @(posedge mclk);
      #1 hblank = 1'h0;
      chk(8'(exp_q.size()), 8'(rx.got_q.size()));
      foreach (exp_q[i]) chk(exp_q[i], rx.got_q[i]);
      rx.got_q = {};
      rd(8'hC1);
      chk(8'(exp_q.size()), d);
      foreach (exp_q[i]) begin
         rd(8'hB0);
         chk(exp_q[i], d);
      end
      rd(8'hB0);
      chk(8'h00, d);
      rd(8'h90);
      if (c > 4'h5) bank = dat_q[0];
      chk(bank, d);
      idle();
      $display("test code %0d done", c);
   endtask : pkt
   // ============================================================
   initial begin
      {mclk, arst_n, reg_wr, reg_rd, slc_valid, slc_last, slc_field} = 7'h00;
      {slc_err, slc_m1, slc_m2, hblank, reg_addr, reg_wdata, slc_data, slc_line} = 38'h0;
      void'($urandom(83362));
      repeat (2) @(posedge mclk);
      #1 arst_n = 1'h1;
      rd(8'hC0);
      chk(8'h02, d);
      rd(8'hD0);
      chk(8'hFF, d);
      rd(8'hB0);
      chk(8'h00, d);
      rd(8'h80);
      chk(8'h00, d);
      // host clears line modes and full field before ram access
      for (int a = 8'hD0; a <= 8'hFC; a++) wr(8'(a), 8'hFF);
      wr(8'hC0, 8'h02);
      wr(8'hC4, 8'h00);
      for (int i = 0; i < 4; i++) wr(8'hC3, 8'h30 + 8'(i));
      rd(8'hC4);
      chk(8'h04, d);
      wr(8'hC4, 8'h00);
      for (int i = 0; i < 4; i++) begin
         rd(8'hC3);
         chk(8'h30 + 8'(i), d);
      end
      wr(8'hC0, 8'h07);
      idle();
      $display("test registers done");
      for (int i = 0; i < 14; i++) pkt(4'((i + 6) % 14));
      final_report();
   end
   // watchdog far beyond the expected run
   initial begin
      #1000000;
      error_cnt++;
      final_report();
   end
endmodule : tb_top
